// ===== card_link_host.sv
// Mobile-side controller for a subscriber card: clock, reset, data line.
// Assumes one 50 MHz clock; the card data pin is asynchronous and is
// synchronised; the card clock is made here by division.
`timescale 1ns/1ps
`default_nettype none
`include "card_link_regs.svh"
// ***************************************************************
// Transmit buffer
// ***************************************************************
module card_tx_fifo #(
  parameter int WIDTH = `TX_WORD_BITS,
  parameter int DEPTH = `TX_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  // Occupancy after this cycle
  always_comb begin
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  // Pointers, count and registered ready
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
    end
  end
  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : card_tx_fifo
// ***************************************************************
// Card link controller
// ***************************************************************
module card_link_host
  import card_link_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic session_on,
  input wire logic clock_stop_allowed,
  input wire logic clock_stop_req,
  input wire tx_word_t tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output rx_word_t rx_word,
  output logic rx_valid,
  output logic atr_done,
  output logic [5:0] atr_count,
  output logic card_idle,
  output logic clock_stopped,
  output logic sleep_refused,
  output logic card_clk,
  output logic card_rst_n,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe
);
  localparam logic [2:0] HALF_LAST = 3'(`CARD_HALF_CYC - 1);
  ctl_state_t state;
  bit_mode_t mode;
  logic [2:0] div_cnt;
  logic clk_rise, clk_run, io_meta, io_sync, hdr_pos1, dropping;
  logic [8:0] etu_cnt;
  logic [3:0] bit_idx;
  logic [9:0] shreg;
  logic [15:0] wait_cnt;
  tx_word_t fifo_word;
  logic fifo_valid, fifo_pop, drop_now, tx_start, rx_start, rx_end, etu_end;
  // Saturating card clock count
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'd1;
  endfunction : sat_inc
  // ***************************************************************
  // Card clock
  // ***************************************************************
  assign clk_run = (state != ST_OFF) && (state != ST_STOPPED);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 3'h0;
      card_clk <= 1'b0;
      clk_rise <= 1'b0;
    end else begin
      clk_rise <= 1'b0;
      if (!clk_run && !card_clk) begin
        div_cnt <= 3'h0; // Park low
      end else if (div_cnt == HALF_LAST) begin
        div_cnt <= 3'h0;
        card_clk <= !card_clk;
        clk_rise <= !card_clk;
      end else begin
        div_cnt <= div_cnt + 3'h1;
      end
    end
  end
  // Data pin synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      io_meta <= 1'b1;
      io_sync <= 1'b1;
    end else begin
      io_meta <= io_in;
      io_sync <= io_meta;
    end
  end

  // ***************************************************************
  // Transmit buffer and command filter
  // ***************************************************************
  card_tx_fifo #(.WIDTH(`TX_WORD_BITS), .DEPTH(`TX_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_data(tx_word),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  // Bytes are taken only from an idle link at a card clock edge
  assign fifo_pop = clk_rise && (state == ST_IDLE) && (mode == BE_IDLE)
    && fifo_valid && io_sync;
  assign drop_now = fifo_word.first ? 1'b0
    : (dropping || (hdr_pos1 && (fifo_word.data == `SLEEP_INS)));
  assign tx_start = fifo_pop && !drop_now;
  assign rx_start = clk_rise && (mode == BE_IDLE) && !io_sync && !fifo_pop
    && ((state == ST_ATR) || (state == ST_IDLE));
  assign etu_end = clk_rise && (etu_cnt == `ETU_LAST);
  assign rx_end = etu_end && (mode == BE_RX) && (bit_idx == `CHAR_LAST_BIT);
  // Header position tracking
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hdr_pos1 <= 1'b0;
      dropping <= 1'b0;
      sleep_refused <= 1'b0;
    end else if (fifo_pop) begin
      hdr_pos1 <= fifo_word.first;
      dropping <= drop_now;
      if (drop_now && !dropping) begin
        sleep_refused <= 1'b1;
      end
    end else if (state == ST_OFF) begin
      sleep_refused <= 1'b0;
    end
  end

  // ***************************************************************
  // Character engine
  // ***************************************************************
  // etu character framing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode <= BE_IDLE;
      etu_cnt <= 9'h0;
      bit_idx <= 4'h0;
      shreg <= 10'h3ff;
      io_oe <= 1'b0;
    end else if (state == ST_OFF || state == ST_RST) begin
      mode <= BE_IDLE;
      etu_cnt <= 9'h0;
      bit_idx <= 4'h0;
      io_oe <= 1'b0;
    end else if (tx_start) begin
      mode <= BE_TX;
      etu_cnt <= 9'h0;
      bit_idx <= 4'h0;
      shreg <= {^fifo_word.data, fifo_word.data, 1'b0};
      io_oe <= 1'b1; // Start bit low
    end else if (rx_start) begin
      mode <= BE_RX;
      etu_cnt <= 9'h0;
      bit_idx <= 4'h0;
    end else if (clk_rise && mode != BE_IDLE) begin
      etu_cnt <= (etu_cnt == `ETU_LAST) ? 9'h0 : etu_cnt + 9'h1;
      if (mode == BE_RX && etu_cnt == `ETU_MID) begin
        shreg <= {io_sync, shreg[9:1]}; // Mid-bit sample
      end
      if (etu_cnt == `ETU_LAST) begin
        bit_idx <= bit_idx + 4'h1;
        case (mode)
          BE_TX: begin
            if (bit_idx == `CHAR_LAST_BIT) begin
              mode <= BE_GUARD;
              bit_idx <= 4'h0;
              io_oe <= 1'b0;
            end else begin
              io_oe <= !shreg[bit_idx + 4'h1];
            end
          end
          BE_RX: begin
            if (bit_idx == `CHAR_LAST_BIT) begin
              mode <= BE_GUARD;
              bit_idx <= 4'h0;
            end
          end
          BE_GUARD: begin
            if (bit_idx == `GUARD_LAST_ETU) begin
              mode <= BE_IDLE;
              bit_idx <= 4'h0;
            end
          end
          default: begin
            mode <= BE_IDLE;
          end
        endcase
      end
    end
  end
  // Received byte out
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_word <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= rx_end;
      if (rx_end) begin
        rx_word.data <= shreg[8:1];
        rx_word.parity_err <= ^shreg[9:1];
      end
    end
  end

  // ***************************************************************
  // Session control
  // ***************************************************************
  // stop, wake, answer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_OFF;
      wait_cnt <= 16'h0;
    end else if (!session_on) begin
      state <= ST_OFF;
      wait_cnt <= 16'h0;
    end else begin
      if (mode != BE_IDLE) begin
        wait_cnt <= 16'h0;
      end else if (clk_rise) begin
        wait_cnt <= sat_inc(wait_cnt);
      end
      case (state)
        ST_OFF: begin
          state <= ST_RST;
          wait_cnt <= 16'h0;
        end
        ST_RST: begin
          if (wait_cnt >= `RST_HOLD_CLKS) begin
            state <= ST_ATR;
            wait_cnt <= 16'h0;
          end
        end
        ST_ATR: begin
          if (mode == BE_IDLE && (atr_count == `ATR_MAX_CHARS
              || wait_cnt >= `ATR_GAP_CLKS)) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (clock_stop_req && clock_stop_allowed && !fifo_valid
              && mode == BE_IDLE && io_sync && wait_cnt >= `STOP_WAIT_CLKS) begin
            state <= ST_STOPPED;
          end
        end
        ST_STOPPED: begin
          if (fifo_valid || !clock_stop_req || !clock_stop_allowed) begin
            state <= ST_WAKE;
            wait_cnt <= 16'h0;
          end
        end
        ST_WAKE: begin
          if (wait_cnt >= `WAKE_WAIT_CLKS) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end
  // Answer to reset progress
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      atr_count <= 6'h0;
      atr_done <= 1'b0;
    end else if (state == ST_OFF || state == ST_RST) begin
      atr_count <= 6'h0;
      atr_done <= 1'b0;
    end else begin
      if (rx_end && state == ST_ATR && atr_count != `ATR_MAX_CHARS) begin
        atr_count <= atr_count + 6'h1;
      end
      atr_done <= (state != ST_ATR);
    end
  end

  // ***************************************************************
  // Pins and status
  // ***************************************************************
  // idle view of the card
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      card_rst_n <= 1'b0;
      io_out <= 1'b0;
      card_idle <= 1'b0;
      clock_stopped <= 1'b0;
    end else begin
      card_rst_n <= (state != ST_OFF) && (state != ST_RST);
      io_out <= 1'b0; // Open drain, drives low only
      card_idle <= (mode == BE_IDLE) && ((state == ST_IDLE)
        || (state == ST_STOPPED) || (state == ST_WAKE));
      clock_stopped <= (state == ST_STOPPED) && !card_clk;
    end
  end
endmodule : card_link_host
`default_nettype wire

// ===== card_link_regs.svh
// Timing counts and fixed values for the card link controller.
// Assumes a 50 MHz system clock; card timing counts are in card clocks except CARD_HALF_CYC, which is in system cycles.
`ifndef CARD_LINK_REGS_SVH
`define CARD_LINK_REGS_SVH

// System clock and wanted card clock rate, in Hz
`define SYS_CLK_HZ 50000000
`define CARD_CLK_HZ 4166666
// System cycles per card clock half period (rounded down to an even divider)
`define CARD_HALF_CYC (`SYS_CLK_HZ / (2 * `CARD_CLK_HZ))
// Card clocks per elementary time unit and mid-bit sample point
`define ETU_CLKS 9'd372
`define ETU_LAST 9'd371
`define ETU_MID 9'd185
// Bits per character (start, 8 data, parity) and guard etu after it
`define CHAR_LAST_BIT 4'd9
`define GUARD_LAST_ETU 4'd1
// Clock stop waits, in card clocks
`define STOP_WAIT_CLKS 16'd1860
`define WAKE_WAIT_CLKS 16'd744
// Reset low time after clock start, in card clocks
`define RST_HOLD_CLKS 16'd400
// Answer to reset limits
`define ATR_MAX_CHARS 6'd33
`define ATR_GAP_CLKS 16'd20000
// Instruction byte of the sleep command
`define SLEEP_INS 8'hfa
// Transmit buffer
`define TX_FIFO_DEPTH 8
`define TX_WORD_BITS 9

`endif

// ===== card_link_pkg.sv
// Types shared by the card link controller and its bench.
// Assumes card_link_regs.svh supplies all numeric constants.
package card_link_pkg;

  // One byte bound for the card, first marks a command header start
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } tx_word_t;

  // One byte received from the card with its parity check
  typedef struct packed {
    logic parity_err;
    logic [7:0] data;
  } rx_word_t;

  // Session control states
  typedef enum logic [2:0] {
    ST_OFF, ST_RST, ST_ATR, ST_IDLE, ST_STOPPED, ST_WAKE
  } ctl_state_t;

  // Character engine modes
  typedef enum logic [1:0] {
    BE_IDLE, BE_TX, BE_RX, BE_GUARD
  } bit_mode_t;

endpackage : card_link_pkg

// ===== card_link_assertions.sv
// Port timing checker for the card link controller.
// Assumes the system clock domain only; bound to card_link_host.
`timescale 1ns/1ps
`default_nettype none
module card_link_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_stop_allowed,
  input wire logic clock_stop_req,
  input wire logic atr_done,
  input wire logic [5:0] atr_count,
  input wire logic clock_stopped,
  input wire logic card_clk,
  input wire logic io_in,
  input wire logic io_oe
);
  // ****************************************
  // Card clock counters
  // ****************************************
  logic [15:0] idle_cnt;
  logic [15:0] wake_cnt;
  logic [15:0] etu_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Card clock rises with the line released
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) idle_cnt <= 16'h0000;
    else if (io_oe || !io_in) idle_cnt <= 16'h0000;
    else if ($rose(card_clk) && idle_cnt != 16'hffff) idle_cnt <= idle_cnt + 16'h0001;
  end

  // Card clock rises since the clock restarted
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) wake_cnt <= 16'hffff;
    else if ($fell(clock_stopped)) wake_cnt <= 16'h0000;
    else if ($rose(card_clk) && wake_cnt != 16'hffff) wake_cnt <= wake_cnt + 16'h0001;
  end

  // Card clock rises since the pin was last pulled
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) etu_cnt <= 16'h0000;
    else if ($rose(io_oe)) etu_cnt <= 16'h0000;
    else if ($rose(card_clk)) etu_cnt <= etu_cnt + 16'h0001;
  end

  // ****************************************
  // Assertions
  // ****************************************
  // duty high half
  clk_high_half_a: assert property ($rose(card_clk) |-> card_clk[*6] ##1 !card_clk)
    else $error("card clock high time wrong");
  clk_low_half_a: assert property ($fell(card_clk) && !clock_stop_req |->
    !card_clk[*6] ##1 card_clk)
    else $error("card clock low time wrong");
  stop_permit_a: assert property ($rose(clock_stopped) |->
    clock_stop_allowed && clock_stop_req)
    else $error("clock stopped without permission");
  stop_low_a: assert property (clock_stopped |-> !card_clk)
    else $error("card clock not parked low");
  stop_wait_a: assert property ($rose(clock_stopped) |-> idle_cnt >= 16'd1860)
    else $error("clock stopped too early");
  wake_wait_a: assert property ($rose(io_oe) |-> wake_cnt >= 16'd744)
    else $error("command sent too soon after restart");
  bit_time_a: assert property ($fell(io_oe) |-> ((etu_cnt + 16'd1) % 16'd372) <= 16'd1)
    else $error("bit edge off the etu grid");
  atr_quiet_a: assert property (!atr_done |-> !io_oe)
    else $error("pin driven during answer to reset");
  atr_length_a: assert property ($rose(atr_done) |-> atr_count <= 6'd33)
    else $error("answer count above limit");
endmodule : card_link_checker

bind card_link_host card_link_checker card_link_checker_i (.clock(clock), .reset_n(reset_n),
  .clock_stop_allowed(clock_stop_allowed), .clock_stop_req(clock_stop_req),
  .atr_done(atr_done), .atr_count(atr_count), .clock_stopped(clock_stopped),
  .card_clk(card_clk), .io_in(io_in), .io_oe(io_oe));
`default_nettype wire

// ===== card_model.sv
// Behavioural subscriber card on clock, reset and data pin.
// Assumes a pulled-up data pin; io_low pulls it down.
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input wire logic card_clk,
  input wire logic card_rst_n,
  input wire logic io,
  output logic io_low
);
  logic [7:0] got [$];
  logic [8:0] sh;
  int i;
  // ****************************************
  // Card behaviour
  // ****************************************
  // one even-parity character
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {^b, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      io_low = !f[k];
      repeat (372) @(posedge card_clk);
    end
    io_low = 1'b0;
    repeat (744) @(posedge card_clk);
  endtask : send

  // no rate flag; a sleep never arrives
  // runs on the given clock, keeps bytes over stops
  initial begin
    io_low = 1'b0;
    @(posedge card_rst_n);
    repeat (500) @(posedge card_clk);
    send(8'h3b);
    forever begin
      @(posedge card_clk);
      if (!io) begin
        repeat (185) @(posedge card_clk);
        for (i = 0; i < 9; i++) begin
          repeat (372) @(posedge card_clk);
          sh = {io, sh[8:1]};
        end
        got.push_back((^sh) ? 8'hxx : sh[7:0]); // Bad parity poisons the byte
        repeat (372) @(posedge card_clk);
      end
    end
  end
endmodule : card_model
`default_nettype wire

// ===== card_link_host_bench.sv
// Self-checking bench for the card link controller and its buffer.
// Assumes card_model on the pin and the checker bound in its own file.
`timescale 1ns/1ps
`default_nettype none
module card_link_host_bench
  import card_link_pkg::*;
;
  logic clock, reset_n, session_on, clock_stop_allowed, clock_stop_req, tx_valid, tx_ready;
  logic rx_valid, atr_done, card_idle, clock_stopped, sleep_refused, card_clk, card_rst_n;
  logic io_out, io_oe, io_low;
  logic [5:0] atr_count;
  tx_word_t tx_word;
  rx_word_t rx_word;
  wire logic io_pin;
  int n_errors, checked, cyc, k;
  // Pulled-up open-drain pin
  assign io_pin = (io_oe || io_low) ? 1'b0 : 1'b1;

  card_link_host card_link_host_i (.clock(clock), .reset_n(reset_n), .session_on(session_on),
    .clock_stop_allowed(clock_stop_allowed), .clock_stop_req(clock_stop_req),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word),
    .rx_valid(rx_valid), .atr_done(atr_done), .atr_count(atr_count), .card_idle(card_idle),
    .clock_stopped(clock_stopped), .sleep_refused(sleep_refused), .card_clk(card_clk),
    .card_rst_n(card_rst_n), .io_in(io_pin), .io_out(io_out), .io_oe(io_oe));
  card_model card_model_i (.card_clk(card_clk), .card_rst_n(card_rst_n), .io(io_pin),
    .io_low(io_low));

  // ****************************************
  // Clock, timeout and checks
  // ****************************************
  // System clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Hang limit
  always @(posedge clock) begin
    cyc++;
    if (cyc == 800000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b got %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h got %h", what, exp, got);
    end
  endtask : check_byte
  task automatic push(input logic f, input logic [7:0] d);
    @(posedge clock);
    #1 tx_word = {f, d};
    tx_valid = 1'b1;
    @(posedge clock);
    while (!tx_ready) @(posedge clock);
    #1 tx_valid = 1'b0;
  endtask : push
  task automatic wait_got(input int n, input int lim);
    for (k = 0; k < lim && card_model_i.got.size() < n; k++) @(posedge clock);
  endtask : wait_got

  // ****************************************
  // Scenarios
  // ****************************************
  // Fill the buffer before the session: one header, a sleep header, one more header
  task automatic test_fifo();
    logic [8:0] words [8] = '{9'h1a0, 9'h1a0, 9'h0fa, 9'h011, 9'h022, 9'h033, 9'h044,
      9'h1c0};
    for (int j = 0; j < 8; j++) begin
      check_bit("tx_ready before push", 1'b1, tx_ready);
      push(words[j][8], words[j][7:0]);
    end
    check_bit("tx_ready when full", 1'b0, tx_ready);
    check_bit("io_out", 1'b0, io_out);
  endtask : test_fifo
  task automatic test_atr();
    #1 session_on = 1'b1;
    for (k = 0; k < 200000 && !rx_valid; k++) @(posedge clock);
    check_bit("card_rst_n in session", 1'b1, card_rst_n);
    check_byte("answer byte", 8'h3b, rx_word.data);
    check_bit("answer parity", 1'b0, rx_word.parity_err);
    for (k = 0; k < 300000 && !atr_done; k++) @(posedge clock);
    check_bit("atr_done", 1'b1, atr_done);
    check_byte("atr_count", 8'h01, {2'b00, atr_count});
  endtask : test_atr
  task automatic test_sleep();
    wait_got(1, 80000);
    check_byte("first command byte", 8'ha0, card_model_i.got[0]);
    wait_got(3, 200000);
    check_bit("tx_ready after drain", 1'b1, tx_ready);
    check_byte("header before sleep", 8'ha0, card_model_i.got[1]);
    check_byte("byte after sleep", 8'hc0, card_model_i.got[2]);
    check_bit("sleep_refused", 1'b1, sleep_refused);
  endtask : test_sleep
  task automatic test_stop();
    #1 clock_stop_req = 1'b1;
    repeat (25000) @(posedge clock);
    check_bit("stop while barred", 1'b0, clock_stopped);
    #1 clock_stop_allowed = 1'b1;
    for (k = 0; k < 30000 && !clock_stopped; k++) @(posedge clock);
    check_bit("clock_stopped", 1'b1, clock_stopped);
    check_bit("card_idle", 1'b1, card_idle);
    push(1'b1, 8'hd0);
    wait_got(4, 80000);
    check_byte("byte after restart", 8'hd0, card_model_i.got[3]);
    check_byte("bytes seen", 8'h04, 8'(card_model_i.got.size()));
  endtask : test_stop

  // Main sequence
  initial begin
    {reset_n, session_on, clock_stop_allowed, clock_stop_req, tx_valid} = 5'h00;
    tx_word = 9'h000;
    repeat (20) @(posedge clock);
    check_bit("card_clk in reset", 1'b0, card_clk);
    check_bit("card_rst_n in reset", 1'b0, card_rst_n);
    #1 reset_n = 1'b1;
    test_fifo();
    test_atr();
    test_sleep();
    test_stop();
    print_verdict();
  end
endmodule : card_link_host_bench
`default_nettype wire
